// [msc_sa_context.sv]
// sa transform context: control word decode, egress/ingress sequence handling,
// replay check and crypto-engine sequence interrupts.
// assumes apb master on core_clk; one packet request pulse at a time.
//
// How it works
// - bits 13..16 all one for macsec; packets refused otherwise
// - cipher from bits 19:17: 101b aes-ctr-128, 111b aes-ctr-256
// - association number bits 27:26 sent out on egress; 00b for ingress
// - sequence type 01b: 32-bit numbers, mask is replay window
// - bit 30 says mask present: zero egress, one ingress
// - reserved bits 12:8 and 20 written zero, read zero
// - egress sequence holds next pn minus one, incremented per packet
// - rollover past 0xfffffff flags error and leaves context unchanged
// - mask is replay window, reset zero means strict ordering
// - 64-bit sci from two little-endian words, always presented
// - pn at or above context with update bit: store pn plus one
// - pn inside replay window: accept, no context change
// - pn below window: replay fail flag, no context change
// - egress increment above threshold sets interrupt status bit 4
// - egress increment wrapping to zero sets interrupt status bit 5
// - packet type 0110b egress or 1111b ingress; others invalid
// - packet processing changes only the sequence number field and the irq status bits
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module msc_sa_context
   import msc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        pkt_valid,
   input  wire logic [31:0] pkt_pn,
   output logic             res_valid,
   output logic             res_pass,
   output logic             seq_error,
   output logic             replay_fail_flag,
   output logic             ctx_invalid,
   output logic [31:0]      tx_pn,
   output logic [1:0]       tx_an,
   output logic [63:0]      sci_value,
   output logic [1:0]       cipher_sel,
   output logic             seq_in_iv_enable,
   output logic             iv_word1_present,
   output logic             iv_word2_present,
   output logic             crypto_irq
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] ctrl;
      // egress: last number sent; ingress: next number expected
      logic [31:0] seq;
      // replay window, only read on ingress
      logic [31:0] mask;
      logic [31:0] sci_lo;
      logic [31:0] sci_hi;
      logic [31:0] seq_threshold_value;
      // crypto-engine interrupt status (write one to clear) and enables
      logic [5:0]  irq_stat;
      logic [5:0]  irq_en;
      // read data captured in the setup cycle
      logic [31:0] prdata;
      // result pulse, then the flags that stand until the next packet
      logic        res_valid;
      logic        res_pass;
      logic        seq_error;
      logic        replay_fail;
      logic        ctx_invalid;
      // number given to the last egress packet that passed
      logic [31:0] tx_pn;
   } msc_state_t;

   msc_state_t st;
   msc_state_t next_st;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic msc_cipher_t msc_cipher(input logic [2:0] alg);
      msc_cipher = MSC_CIPH_NONE;
      if (alg == MSC_ALG_CTR128) begin
         msc_cipher = MSC_CIPH_AES128;
      end else if (alg == MSC_ALG_CTR256) begin
         msc_cipher = MSC_CIPH_AES256;
      end
   endfunction

   function automatic logic msc_hit(input logic [7:0] a, input logic [7:0] ofs);
      msc_hit = (a == ofs);
   endfunction

   // inside the replay window; a negative lower edge means every number fits
   function automatic logic msc_in_window(input logic [31:0] pn, input logic [32:0] low);
      msc_in_window = ({1'b0, pn} >= low) || low[32];
   endfunction

   // irq register image: enables in the upper half, status in the lower
   function automatic logic [31:0] msc_irq_word(input logic [5:0] en, input logic [5:0] stat);
      msc_irq_word = {10'h000, en, 10'h000, stat};
   endfunction

   // status register image: result flags above the context direction
   function automatic logic [31:0] msc_status_word(input logic [4:0] flags);
      msc_status_word = {27'h0000000, flags};
   endfunction

   logic [3:0]  ptype;
   logic        is_egr;
   logic        is_igr;
   logic        macsec_ok;
   logic        apb_wr;
   logic        apb_rd;
   logic [32:0] win_low;
   logic [31:0] seq_inc;
   logic        mapped;

   // ---------------------------------------------------------------
   // control word fields
   // ---------------------------------------------------------------
   // one decode of the stored word serves the packet path and the pins
   logic [2:0]  f_alg;
   logic [1:0]  f_an;
   logic [1:0]  f_seqt;
   logic        f_upd;
   logic        f_ivfmt;
   logic        f_enca;
   logic        f_key;
   logic        f_maskp;

   assign f_alg     = st.ctrl[MSC_ALG_LSB +: 3];
   assign f_an      = st.ctrl[MSC_AN_LSB +: 2];
   assign f_seqt    = st.ctrl[MSC_SEQT_LSB +: 2];
   assign f_upd     = st.ctrl[MSC_UPD_BIT];
   assign f_ivfmt   = st.ctrl[MSC_IVFMT_BIT];
   assign f_enca    = st.ctrl[MSC_ENCA_BIT];
   assign f_key     = st.ctrl[MSC_KEY_BIT];
   assign f_maskp   = st.ctrl[MSC_MASKP_BIT];

   // the direction needs both the packet type and the mask-present bit,
   // so a record built for one direction cannot run as the other
   assign ptype     = st.ctrl[MSC_TOP_LSB +: 4];
   assign is_egr    = (ptype == MSC_TOP_EGR) && !f_maskp;
   assign is_igr    = (ptype == MSC_TOP_IGR) && f_maskp;
   // a missing transform bit, a wrong sequence type or an unknown cipher
   // leaves the record unusable
   assign macsec_ok = f_upd && f_ivfmt && f_enca && f_key && (f_seqt == MSC_SEQT_32)
                      && (msc_cipher(f_alg) != MSC_CIPH_NONE);
   assign apb_wr    = psel && penable && pwrite;
   // read data is captured in the setup cycle and stands through the access phase
   assign apb_rd    = psel && !penable && !pwrite;
   // lower window edge kept 33 bits wide so a large mask cannot wrap upward
   assign win_low   = {1'b0, st.seq} - {1'b0, st.mask};
   assign seq_inc   = st.seq + 32'h0000_0001;
   assign mapped    = msc_hit(paddr, MSC_OFS_CTRL_WORD) || msc_hit(paddr, MSC_OFS_SEQ)
                      || msc_hit(paddr, MSC_OFS_MASK) || msc_hit(paddr, MSC_OFS_SCI_LO)
                      || msc_hit(paddr, MSC_OFS_SCI_HI) || msc_hit(paddr, MSC_OFS_THRESH)
                      || msc_hit(paddr, MSC_OFS_IRQ) || msc_hit(paddr, MSC_OFS_STATUS);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   // one packet result per cycle of pkt_valid, one cycle later.
   // egress: the stored word is one below the number to send; the
   // ceiling stops the count and freezes the context, so every later
   // egress packet on it reports the same sequence error until software
   // installs a fresh association.
   // ingress: a number at or above the stored word passes and may move it
   // forward; one below it passes only inside the replay window.
   // register writes come after the packet path so that, in a cycle with
   // both, a status bit a packet raises from zero survives a clear in that cycle.
   always_comb begin
      next_st           = st;
      next_st.res_valid = 1'b0;
      // packet processing; of the registers only the sequence word and the irq status are written here
      if (pkt_valid) begin
         next_st.res_valid   = 1'b1;
         next_st.res_pass    = 1'b0;
         next_st.seq_error   = 1'b0;
         next_st.replay_fail = 1'b0;
         next_st.ctx_invalid = 1'b0;
         if (!macsec_ok || !(is_egr || is_igr)) begin
            // a broken record is never allowed to touch the sequence word
            next_st.ctx_invalid = 1'b1;
         end else if (is_egr) begin
            if (st.seq == MSC_SEQ_MAX) begin
               // frozen at the ceiling: nothing is stored, so the error repeats
               next_st.seq_error = 1'b1;
            end else begin
               next_st.seq      = seq_inc;
               next_st.tx_pn    = seq_inc;
               next_st.res_pass = 1'b1;
               // the new value is compared, since it is the increment that crosses
               if (seq_inc > st.seq_threshold_value) begin
                  next_st.irq_stat[MSC_IRQ_THR_BIT] = 1'b1;
               end
            end
            // a wrap from the all-ones word is still reported as a rollover
            if (st.seq == 32'hffff_ffff) begin
               next_st.irq_stat[MSC_IRQ_ROL_BIT] = 1'b1;
            end
         end else begin
            if (pkt_pn >= st.seq) begin
               // newest number so far: pass, and move forward if allowed
               next_st.res_pass = 1'b1;
               if (f_upd) begin
                  next_st.seq = pkt_pn + 32'h0000_0001;
               end
            end else if (msc_in_window(pkt_pn, win_low)) begin
               // late but inside the window: accepted, context left alone
               next_st.res_pass = 1'b1;
            end else begin
               next_st.replay_fail = 1'b1;
            end
         end
      end
      // register writes; status bits a packet raised from zero above win over clears
      if (apb_wr) begin
         case (paddr)
            MSC_OFS_CTRL_WORD: begin
               // reserved bits are never stored, so they cannot leak into a decode
               next_st.ctrl = pwdata & ~MSC_CTRL_RSVD;
            end
            MSC_OFS_SEQ: begin
               // a packet in the same cycle owns the sequence word; the write
               // is dropped rather than merged with the packet's update
               if (!pkt_valid) begin
                  next_st.seq = pwdata;
               end
            end
            MSC_OFS_MASK: begin
               next_st.mask = pwdata;
            end
            MSC_OFS_SCI_LO: begin
               next_st.sci_lo = pwdata;
            end
            MSC_OFS_SCI_HI: begin
               next_st.sci_hi = pwdata;
            end
            MSC_OFS_THRESH: begin
               next_st.seq_threshold_value = pwdata;
            end
            MSC_OFS_IRQ: begin
               // low half: write-one-to-clear status, upper half: enables
               // a bit raised from zero by a packet in this very cycle is kept
               next_st.irq_stat = next_st.irq_stat & ~(pwdata[5:0] & ~(next_st.irq_stat & ~st.irq_stat));
               next_st.irq_en   = pwdata[21:16];
            end
            default: ;
         endcase
      end
      if (apb_rd) begin
         case (paddr)
            MSC_OFS_CTRL_WORD: begin
               next_st.prdata = st.ctrl & ~MSC_CTRL_RSVD;
            end
            MSC_OFS_SEQ: begin
               next_st.prdata = st.seq;
            end
            MSC_OFS_MASK: begin
               next_st.prdata = st.mask;
            end
            MSC_OFS_SCI_LO: begin
               next_st.prdata = st.sci_lo;
            end
            MSC_OFS_SCI_HI: begin
               next_st.prdata = st.sci_hi;
            end
            MSC_OFS_THRESH: begin
               next_st.prdata = st.seq_threshold_value;
            end
            MSC_OFS_IRQ: begin
               next_st.prdata = msc_irq_word(st.irq_en, st.irq_stat);
            end
            MSC_OFS_STATUS: begin
               next_st.prdata = msc_status_word({st.ctx_invalid, st.replay_fail, st.seq_error, is_igr, is_egr});
            end
            default: begin
               // unmapped reads return zero alongside the slave error
               next_st.prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st                     <= '0;
         st.ctrl                <= MSC_RST_CTRL;
         st.seq                 <= MSC_RST_SEQ;
         st.mask                <= MSC_RST_MASK;
         // all-ones threshold: no interrupt before software programs one
         st.seq_threshold_value <= MSC_RST_THRESH;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // every access completes in its first access cycle: no wait states
   assign pready           = 1'b1;
   // the error is only shown during the access phase of an unmapped word
   assign pslverr          = psel && penable && !mapped;
   // result pins mirror registered state; res_valid pulses, the flags stand until the next packet
   assign prdata           = st.prdata;
   assign res_valid        = st.res_valid;
   assign res_pass         = st.res_pass;
   assign seq_error        = st.seq_error;
   assign replay_fail_flag = st.replay_fail;
   assign ctx_invalid      = st.ctx_invalid;
   assign tx_pn            = st.tx_pn;
   // the association number only means something on egress
   assign tx_an            = is_egr ? f_an : 2'h0;
   assign sci_value        = {st.sci_hi, st.sci_lo};
   assign cipher_sel       = msc_cipher(f_alg);
   // iv presence bits pass through as stored; software is trusted to set them
   assign seq_in_iv_enable = f_ivfmt;
   assign iv_word1_present = st.ctrl[MSC_IV0_BIT];
   assign iv_word2_present = st.ctrl[MSC_IV1_BIT];
   assign crypto_irq       = |(st.irq_stat & st.irq_en);
endmodule
`default_nettype wire

// [msc_pkg.sv]
// package for the sa context / sequence block
// assumes a single core clock domain and apb register access
`default_nettype none
package msc_pkg;
   // apb byte addresses of the block's registers
   localparam logic [7:0] MSC_OFS_CTRL_WORD  = 8'h00;
   localparam logic [7:0] MSC_OFS_SEQ        = 8'h04;
   localparam logic [7:0] MSC_OFS_MASK       = 8'h08;
   localparam logic [7:0] MSC_OFS_SCI_LO     = 8'h0c;
   localparam logic [7:0] MSC_OFS_SCI_HI     = 8'h10;
   localparam logic [7:0] MSC_OFS_THRESH     = 8'h14;
   localparam logic [7:0] MSC_OFS_IRQ        = 8'h18;
   localparam logic [7:0] MSC_OFS_STATUS     = 8'h1c;
   // control word field positions
   localparam int MSC_TOP_LSB    = 0;
   localparam int MSC_IV0_BIT    = 5;
   localparam int MSC_IV1_BIT    = 6;
   localparam int MSC_IV2_BIT    = 7;
   localparam int MSC_UPD_BIT    = 13;
   localparam int MSC_IVFMT_BIT  = 14;
   localparam int MSC_ENCA_BIT   = 15;
   localparam int MSC_KEY_BIT    = 16;
   localparam int MSC_ALG_LSB    = 17;
   localparam int MSC_DIG_LSB    = 21;
   localparam int MSC_AUTH_LSB   = 23;
   localparam int MSC_AN_LSB     = 26;
   localparam int MSC_SEQT_LSB   = 28;
   localparam int MSC_MASKP_BIT  = 30;
   localparam int MSC_CID_BIT    = 31;
   // reserved bits 12:8 and 20 read back as zero
   localparam logic [31:0] MSC_CTRL_RSVD = 32'h0010_1f00;
   // field codes
   localparam logic [3:0] MSC_TOP_EGR    = 4'h6;
   localparam logic [3:0] MSC_TOP_IGR    = 4'hf;
   localparam logic [2:0] MSC_ALG_CTR128 = 3'h5;
   localparam logic [2:0] MSC_ALG_CTR256 = 3'h7;
   localparam logic [1:0] MSC_SEQT_32    = 2'h1;
   // interrupt status bit positions
   localparam int MSC_IRQ_THR_BIT = 4;
   localparam int MSC_IRQ_ROL_BIT = 5;
   // reset values
   localparam logic [31:0] MSC_RST_CTRL   = 32'h0000_0000;
   localparam logic [31:0] MSC_RST_SEQ    = 32'h0000_0000;
   localparam logic [31:0] MSC_RST_MASK   = 32'h0000_0000;
   localparam logic [31:0] MSC_RST_THRESH = 32'hffff_ffff;
   // egress sequence ceiling, at which the context is frozen
   localparam logic [31:0] MSC_SEQ_MAX    = 32'h0fff_ffff;

   typedef enum logic [1:0] {
      MSC_CIPH_NONE,
      MSC_CIPH_AES128,
      MSC_CIPH_AES256
   } msc_cipher_t;
endpackage
`default_nettype wire

// [msc_sa_context_asserts.sv]
// checker for the sa context block, bound onto its ports
// assumes one core_clk domain with asynchronous active-low arst_n
`timescale 1ns/1ps
`default_nettype none
module msc_sa_context_asserts
   import msc_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        arst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   input wire logic        pkt_valid,
   input wire logic        res_valid,
   input wire logic        res_pass,
   input wire logic        seq_error,
   input wire logic        replay_fail_flag,
   input wire logic        ctx_invalid,
   input wire logic [31:0] tx_pn,
   input wire logic [1:0]  tx_an,
   input wire logic [1:0]  cipher_sel,
   input wire logic        seq_in_iv_enable
);
   logic [31:0] ctrl_copy;
   logic        egr;
   logic        igr;
   logic [2:0]  alg;
   // mirror of the control word; packet traffic must never change it
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_copy <= '0;
      end else if (psel && penable && pwrite && paddr == MSC_OFS_CTRL_WORD) begin
         ctrl_copy <= pwdata & ~MSC_CTRL_RSVD;
      end
   end
   assign egr = ctrl_copy[3:0] == MSC_TOP_EGR && !ctrl_copy[MSC_MASKP_BIT];
   assign igr = ctrl_copy[3:0] == MSC_TOP_IGR && ctrl_copy[MSC_MASKP_BIT];
   assign alg = ctrl_copy[MSC_ALG_LSB+:3];
   default clocking dclk @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   property p_res_one; 1 |=> res_valid == $past(pkt_valid); endproperty
   a_res_one: assert property (p_res_one) else $error("result strobe misplaced");
   property p_flag_hold; !res_valid |-> $stable({res_pass, seq_error, replay_fail_flag, ctx_invalid}); endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flags moved without result");
   property p_one_kind; res_valid |-> $onehot({res_pass, seq_error, replay_fail_flag, ctx_invalid}); endproperty
   a_one_kind: assert property (p_one_kind) else $error("result kinds overlap");
   property p_txpn_cause; $changed(tx_pn) |-> res_valid && res_pass && egr; endproperty
   a_txpn_cause: assert property (p_txpn_cause) else $error("tx_pn moved without egress pass");
   property p_eg_bump; res_valid && res_pass && egr && $past(res_valid && res_pass) |-> tx_pn == $past(tx_pn) + 32'h1; endproperty
   a_eg_bump: assert property (p_eg_bump) else $error("egress number not bumped by one");
   property p_seqerr_dir; res_valid && seq_error |-> egr; endproperty
   a_seqerr_dir: assert property (p_seqerr_dir) else $error("sequence error outside egress");
   property p_replay_dir; res_valid && replay_fail_flag |-> igr; endproperty
   a_replay_dir: assert property (p_replay_dir) else $error("replay failure outside ingress");
   property p_bad_type; res_valid && !egr && !igr |-> ctx_invalid; endproperty
   a_bad_type: assert property (p_bad_type) else $error("bad packet type accepted");
   property p_cipher; 1 |-> cipher_sel == (alg == 3'h5 ? 2'h1 : (alg == 3'h7 ? 2'h2 : 2'h0)); endproperty
   a_cipher: assert property (p_cipher) else $error("cipher select wrong");
   property p_an; egr || igr |-> tx_an == (egr ? ctrl_copy[27:26] : 2'h0); endproperty
   a_an: assert property (p_an) else $error("association number wrong");
   property p_ivfmt; 1 |-> seq_in_iv_enable == ctrl_copy[MSC_IVFMT_BIT]; endproperty
   a_ivfmt: assert property (p_ivfmt) else $error("seq_in_iv_enable bit wrong");
   property p_slverr; psel && penable |-> pslverr == (paddr > 8'h1c || paddr[1:0] != 2'h0); endproperty
   a_slverr: assert property (p_slverr) else $error("slave error wrong");
endmodule
bind msc_sa_context msc_sa_context_asserts msc_sa_context_asserts_inst (.core_clk(core_clk), .arst_n(arst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .pkt_valid(pkt_valid), .res_valid(res_valid), .res_pass(res_pass), .seq_error(seq_error),
   .replay_fail_flag(replay_fail_flag), .ctx_invalid(ctx_invalid), .tx_pn(tx_pn), .tx_an(tx_an),
   .cipher_sel(cipher_sel), .seq_in_iv_enable(seq_in_iv_enable));
`default_nettype wire

// [test_msc_sa_context.sv]
// self-checking bench for the sa context block
// assumes msc_pkg and msc_sa_context are compiled first; bench is apb master and packet source
`timescale 1ns/1ps
`default_nettype none
module test_msc_sa_context
   import msc_pkg::*;
;
   logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr, pkt_valid, res_valid, res_pass;
   logic        seq_error, replay_fail_flag, ctx_invalid, seq_in_iv_enable, iv_word1_present;
   logic        iv_word2_present, crypto_irq, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, pkt_pn, tx_pn, q, ce;
   logic [1:0]  tx_an, cipher_sel;
   logic [63:0] sci_value;
   int          n_mismatch, comparisons;
   msc_sa_context msc_sa_context_inst (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .pkt_valid(pkt_valid), .pkt_pn(pkt_pn), .res_valid(res_valid), .res_pass(res_pass), .seq_error(seq_error),
      .replay_fail_flag(replay_fail_flag), .ctx_invalid(ctx_invalid), .tx_pn(tx_pn), .tx_an(tx_an),
      .sci_value(sci_value), .cipher_sel(cipher_sel), .seq_in_iv_enable(seq_in_iv_enable),
      .iv_word1_present(iv_word1_present), .iv_word2_present(iv_word2_present), .crypto_irq(crypto_irq));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   function automatic logic [31:0] cw(input logic [3:0] top, input logic [2:0] alg, input logic [1:0] an,
                                      input logic mp);
      cw = {1'b1, mp, 2'h1, an, 3'h4, 2'h2, 1'b0, alg, 4'hf, 5'h00, 3'h3, 1'b0, top};
   endfunction
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      chk({q, err}, {e, 1'b0});
   endtask
   // n back-to-back requests; the outcome of the last is compared
   task automatic pkt(input logic [31:0] pn, input int n, input logic [3:0] e);
      @(posedge core_clk);
      pkt_valid <= 1'b1;
      pkt_pn <= pn;
      repeat (n) @(posedge core_clk);
      pkt_valid <= 1'b0;
      #1;
      chk({res_valid, res_pass, seq_error, replay_fail_flag, ctx_invalid}, {1'b1, e});
   endtask
   task automatic conclude;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {arst_n, psel, penable, pwrite, pkt_valid, paddr, pwdata, pkt_pn} = '0;
      repeat (6) @(posedge core_clk);
      arst_n <= 1'b1;
      rdc(MSC_OFS_THRESH, MSC_RST_THRESH);
      rdc(MSC_OFS_MASK, MSC_RST_MASK);
      wr(MSC_OFS_CTRL_WORD, 32'hffff_ffff);
      rdc(MSC_OFS_CTRL_WORD, ~MSC_CTRL_RSVD);
      apb(8'h20, 1'b0, 32'h0);
      chk({q, err}, {32'h0, 1'b1});
      ce = cw(MSC_TOP_EGR, MSC_ALG_CTR128, 2'h2, 1'b0);
      wr(MSC_OFS_CTRL_WORD, ce);
      wr(MSC_OFS_SEQ, 32'h0);
      wr(MSC_OFS_THRESH, 32'h1);
      wr(MSC_OFS_IRQ, 32'h0010_0000);
      wr(MSC_OFS_SCI_LO, 32'h1234_5678);
      wr(MSC_OFS_SCI_HI, 32'h9abc_def0);
      chk(sci_value, 64'h9abc_def0_1234_5678);
      chk({cipher_sel, tx_an, seq_in_iv_enable}, {2'h1, 2'h2, 1'b1});
      chk({iv_word1_present, iv_word2_present}, 2'b11);
      pkt(32'h0, 2, 4'b1000);
      chk({tx_pn, crypto_irq}, {32'h2, 1'b1});
      rdc(MSC_OFS_SEQ, 32'h2);
      rdc(MSC_OFS_CTRL_WORD, ce);
      wr(MSC_OFS_IRQ, 32'h0010_0010);
      chk(crypto_irq, 1'b0);
      wr(MSC_OFS_SEQ, MSC_SEQ_MAX);
      repeat (2) begin
         pkt(32'h0, 1, 4'b0100);
         rdc(MSC_OFS_SEQ, MSC_SEQ_MAX);
      end
      wr(MSC_OFS_SEQ, 32'hffff_ffff);
      pkt(32'h0, 1, 4'b1000);
      rdc(MSC_OFS_IRQ, 32'h0010_0020);
      for (int b = 13; b <= 16; b++) begin
         wr(MSC_OFS_CTRL_WORD, ce & ~(32'h1 << b));
         pkt(32'h0, 1, 4'b0001);
      end
      wr(MSC_OFS_CTRL_WORD, ce ^ 32'h3000_0000);
      pkt(32'h0, 1, 4'b0001);
      wr(MSC_OFS_CTRL_WORD, cw(4'h5, MSC_ALG_CTR128, 2'h0, 1'b0));
      pkt(32'h0, 1, 4'b0001);
      wr(MSC_OFS_CTRL_WORD, cw(MSC_TOP_EGR, MSC_ALG_CTR128, 2'h0, 1'b1));
      pkt(32'h0, 1, 4'b0001);
      wr(MSC_OFS_CTRL_WORD, cw(MSC_TOP_EGR, 3'h0, 2'h0, 1'b0));
      chk(cipher_sel, 2'h0);
      pkt(32'h0, 1, 4'b0001);
      wr(MSC_OFS_CTRL_WORD, cw(MSC_TOP_IGR, MSC_ALG_CTR256, 2'h0, 1'b1));
      chk({cipher_sel, tx_an}, {2'h2, 2'h0});
      wr(MSC_OFS_SEQ, 32'd1);
      pkt(32'd0, 1, 4'b0010);
      pkt(32'd1, 1, 4'b1000);
      rdc(MSC_OFS_SEQ, 32'd2);
      wr(MSC_OFS_SEQ, 32'd10);
      pkt(32'd9, 1, 4'b0010);
      wr(MSC_OFS_MASK, 32'd3);
      pkt(32'd12, 1, 4'b1000);
      rdc(MSC_OFS_SEQ, 32'd13);
      pkt(32'd10, 1, 4'b1000);
      pkt(32'd9, 1, 4'b0010);
      rdc(MSC_OFS_SEQ, 32'd13);
      wr(MSC_OFS_MASK, 32'hffff_ffff);
      pkt(32'd1, 1, 4'b1000);
      conclude();
   end
   // whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      n_mismatch++;
      conclude();
   end
endmodule
`default_nettype wire
